// [ssctl_top.sv]
`timescale 1ns/1ps
`include "ssctl_map.svh"
module ssctl_top #(
  parameter int RESET_LONG_CYCLES = `SSCTL_RESET_LONG_WDT
) (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic clk_en, // clock enable
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire logic [3:0] clock_select_fuses, // source select fuses
  input wire logic [1:0] startup_time_fuses, // start-up fuses
  input wire logic divide_by_eight_fuse, // zero means programmed
  input wire logic external_clock_input, // external clock level
  input wire logic rc_osc_clk, // internal RC level
  input wire logic watchdog_timer_osc_clk, // watchdog oscillator level
  input wire logic lf_osc_clk, // low-frequency oscillator level
  input wire logic xtal_osc_clk, // crystal oscillator level
  input wire logic sleep_req, // enter sleep
  input wire logic wake_evt, // wake from sleep
  input wire logic ext_int_n, // external interrupt pin, active low
  output logic sys_clk_tick, // divided system clock cycle
  output logic core_clock_tick, // core domain cycle
  output logic peripheral_clock_tick, // peripheral domain cycle
  output logic program_memory_clock_tick, // program memory domain cycle
  output logic async_timer_clock_tick, // async timer domain cycle
  output logic converter_clock_tick, // converter domain cycle
  output logic cpu_run, // instructions may execute
  output logic clock_output_pin, // system clock level out
  output logic port_b_pin_four_clk_in, // pin four is clock input
  output logic osc_pins_dedicated, // both pins belong to oscillator
  output logic async_int_wake // interrupt seen without clocks
);
  ssctl_pkg::ssctl_state_t state_reg;
  ssctl_pkg::ssctl_src_t new_src;
  logic [3:0] sel_field_reg;
  logic [1:0] startup_field_reg;
  logic div_en_reg;
  logic [4:0] gate_reg;
  logic go_reg;
  logic ck_start_reg;
  logic wdt_start_reg;
  logic [13:0] ck_target_reg;
  logic [13:0] wdt_target_reg;
  logic [4:0] lvl_prev_reg;
  logic mux_prev_reg;
  logic [2:0] div_cnt_reg;
  logic ack_reg;
  logic ck_done;
  logic wdt_done;
  logic [4:0] levels;
  logic [4:0] edges;
  logic mux_edge;
  logic sys_tick_w;
  logic core_en;
  logic periph_en;
  logic wr_en;
  logic sw_req;
  ssctl_sw_if sw_if ();

  // decode of the four-bit select code
  function automatic ssctl_pkg::ssctl_src_t decode_src(input logic [3:0] code);
    ssctl_pkg::ssctl_src_t s;
    s = ssctl_pkg::SRC_RC;
    casez (code)
      `SSCTL_CODE_EXT: s = ssctl_pkg::SRC_EXT; // see R3
      `SSCTL_CODE_RC: s = ssctl_pkg::SRC_RC; // see R3
      `SSCTL_CODE_WDT: s = ssctl_pkg::SRC_WDT; // see R3
      4'b01??: s = ssctl_pkg::SRC_LF; // see R4
      4'b1???: s = ssctl_pkg::SRC_XTAL; // see R4
      default: s = ssctl_pkg::SRC_RC;
    endcase
    return s;
  endfunction

  // start-up cycles on wake or switch for a given source
  function automatic logic [13:0] wake_count(input ssctl_pkg::ssctl_src_t s);
    logic [13:0] n;
    n = `SSCTL_WAKE_CK; // see R18
    if (s == ssctl_pkg::SRC_LF || s == ssctl_pkg::SRC_XTAL)
      n = `SSCTL_OSC_WAKE_CK;
    return n;
  endfunction

  // source levels and their rising edges, pins are sampled without a synchronizer
  assign levels = {xtal_osc_clk, lf_osc_clk, watchdog_timer_osc_clk, rc_osc_clk,
    external_clock_input};
  assign edges = levels & ~lvl_prev_reg;
  assign mux_edge = sw_if.clk_level && !mux_prev_reg;
  assign sys_tick_w = mux_edge && (!div_en_reg || div_cnt_reg == 3'h7);
  assign core_en = (state_reg == ssctl_pkg::ST_RUN) && !gate_reg[0]; // see R13
  assign periph_en = (state_reg == ssctl_pkg::ST_RUN) && !gate_reg[1]; // see R12
  assign new_src = decode_src(wb_dat_i[3:0]);
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign sw_req = wr_en && wb_adr_i == `SSCTL_ADR_SELECT && wb_sel_i[1]
    && wb_dat_i[`SSCTL_SWITCH_BIT] && state_reg == ssctl_pkg::ST_RUN;

  // handover multiplexer and its control
  assign sw_if.levels = levels;
  assign sw_if.req = decode_src(sel_field_reg);
  assign sw_if.go = go_reg;
  ssctl_clk_switch u_switch (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .sw(sw_if.sw)
  );

  // start-up counter on the selected source
  ssctl_tick_counter #(.W(14)) u_ck_cnt (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .start(ck_start_reg),
    .tick(edges[sw_if.active]),
    .target(ck_target_reg),
    .done(ck_done)
  );

  // power delay counter on the watchdog oscillator
  ssctl_tick_counter #(.W(14)) u_wdt_cnt (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .start(wdt_start_reg),
    .tick(edges[ssctl_pkg::SRC_WDT]), // see R8
    .target(wdt_target_reg),
    .done(wdt_done)
  );

  // control sequence: reset load, reset delays, run, switch, sleep, wake
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      state_reg <= ssctl_pkg::ST_LOAD;
      go_reg <= 1'b0;
      ck_start_reg <= 1'b0;
      wdt_start_reg <= 1'b0;
      ck_target_reg <= `SSCTL_RESET_CK;
      wdt_target_reg <= `SSCTL_RESET_SHORT_WDT;
    end
    else if (clk_en)
    begin
      go_reg <= 1'b0;
      ck_start_reg <= 1'b0;
      wdt_start_reg <= 1'b0;
      case (state_reg)
        ssctl_pkg::ST_LOAD:
        begin
          go_reg <= 1'b1; // see R1
          state_reg <= ssctl_pkg::ST_RST_SW;
        end
        ssctl_pkg::ST_RST_SW:
          if (!sw_if.busy && !go_reg)
          begin
            ck_target_reg <= `SSCTL_RESET_CK; // see R18
            ck_start_reg <= 1'b1;
            state_reg <= ssctl_pkg::ST_RST_CK;
          end
        ssctl_pkg::ST_RST_CK:
          if (ck_done && !ck_start_reg)
          begin
            if (startup_field_reg == `SSCTL_STARTUP_NONE)
              state_reg <= ssctl_pkg::ST_RUN;
            else
            begin
              wdt_target_reg <= (startup_field_reg == `SSCTL_STARTUP_SHORT) ? // see R9
                `SSCTL_RESET_SHORT_WDT : 14'(RESET_LONG_CYCLES);
              wdt_start_reg <= 1'b1;
              state_reg <= ssctl_pkg::ST_RST_WDT;
            end
          end
        ssctl_pkg::ST_RST_WDT:
          if (wdt_done && !wdt_start_reg)
            state_reg <= ssctl_pkg::ST_RUN; // see R8
        ssctl_pkg::ST_RUN:
          if (sw_req && new_src != sw_if.active)
          begin
            go_reg <= 1'b1; // see R2
            state_reg <= ssctl_pkg::ST_SWITCH;
          end
          else if (sleep_req)
            state_reg <= ssctl_pkg::ST_SLEEP; // see R12
        ssctl_pkg::ST_SWITCH:
          if (!sw_if.busy && !go_reg)
          begin
            ck_target_reg <= wake_count(sw_if.active); // see R7
            ck_start_reg <= 1'b1;
            state_reg <= ssctl_pkg::ST_WAKE;
          end
        ssctl_pkg::ST_SLEEP:
          if (wake_evt)
          begin
            ck_target_reg <= wake_count(sw_if.active); // see R7
            ck_start_reg <= 1'b1;
            state_reg <= ssctl_pkg::ST_WAKE;
          end
        ssctl_pkg::ST_WAKE:
          if (ck_done && !ck_start_reg)
            state_reg <= ssctl_pkg::ST_RUN; // see R7
        default:
          state_reg <= ssctl_pkg::ST_LOAD;
      endcase
    end

  // selection register: fuse copy at reset, software writes while running
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      sel_field_reg <= `SSCTL_CODE_RC;
      startup_field_reg <= `SSCTL_STARTUP_NONE;
      div_en_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state_reg == ssctl_pkg::ST_LOAD)
      begin
        sel_field_reg <= clock_select_fuses; // see R10
        startup_field_reg <= startup_time_fuses; // see R10
        div_en_reg <= !divide_by_eight_fuse; // see R6, see R11
      end
      else if (wr_en && wb_adr_i == `SSCTL_ADR_SELECT && state_reg == ssctl_pkg::ST_RUN)
      begin
        if (wb_sel_i[0])
        begin
          sel_field_reg <= wb_dat_i[3:0]; // see R2
          startup_field_reg <= wb_dat_i[5:4];
        end
        if (wb_sel_i[1])
          div_en_reg <= wb_dat_i[`SSCTL_DIV8_BIT];
      end
    end

  // domain gating register
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      gate_reg <= `SSCTL_GATE_RESET;
    else if (clk_en && wr_en && wb_adr_i == `SSCTL_ADR_GATE && wb_sel_i[0])
      gate_reg <= wb_dat_i[4:0]; // see R12

  // edge history and system clock prescaler
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      lvl_prev_reg <= 5'h00;
      mux_prev_reg <= 1'b0;
      div_cnt_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      lvl_prev_reg <= levels;
      mux_prev_reg <= sw_if.clk_level;
      if (mux_edge)
        div_cnt_reg <= div_cnt_reg + 3'h1; // see R11
    end

  // domain clock outputs
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      sys_clk_tick <= 1'b0;
      core_clock_tick <= 1'b0;
      peripheral_clock_tick <= 1'b0;
      program_memory_clock_tick <= 1'b0;
      async_timer_clock_tick <= 1'b0;
      converter_clock_tick <= 1'b0;
      cpu_run <= 1'b0;
      clock_output_pin <= 1'b0;
    end
    else if (clk_en)
    begin
      sys_clk_tick <= sys_tick_w;
      core_clock_tick <= sys_tick_w && core_en; // see R13
      peripheral_clock_tick <= sys_tick_w && periph_en; // see R14
      program_memory_clock_tick <= sys_tick_w && core_en && !gate_reg[2];
      async_timer_clock_tick <= edges[ssctl_pkg::SRC_LF] && !gate_reg[3]; // see R15
      converter_clock_tick <= sys_tick_w && !gate_reg[4] // see R16
        && (state_reg == ssctl_pkg::ST_RUN || state_reg == ssctl_pkg::ST_SLEEP);
      cpu_run <= core_en; // see R7
      clock_output_pin <= sw_if.clk_level;
    end

  // pin roles follow the active source
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      port_b_pin_four_clk_in <= 1'b0;
      osc_pins_dedicated <= 1'b0;
    end
    else if (clk_en)
    begin
      port_b_pin_four_clk_in <= sw_if.active == ssctl_pkg::SRC_EXT; // see R5
      osc_pins_dedicated <= sw_if.active == ssctl_pkg::SRC_LF // see R5
        || sw_if.active == ssctl_pkg::SRC_XTAL;
    end

  // level interrupt passes straight through, no clock needed
  assign async_int_wake = !ext_int_n; // see R14

  // bus slave: ack one cycle after strobe, dropped the cycle after
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      ack_reg <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      if (wb_cyc_i && wb_stb_i && !ack_reg)
        case (wb_adr_i)
          `SSCTL_ADR_SELECT:
            wb_dat_o <= {22'h0, div_en_reg, 3'h0, startup_field_reg, sel_field_reg};
          `SSCTL_ADR_GATE:
            wb_dat_o <= {27'h0, gate_reg};
          `SSCTL_ADR_STATUS:
            wb_dat_o <= {21'h0, state_reg, 2'h0, sw_if.busy, cpu_run, 1'b0, sw_if.active};
          default:
            wb_dat_o <= 32'h0000_0000;
        endcase
    end
  assign wb_ack_o = ack_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_load;
    clk_en && state_reg == ssctl_pkg::ST_LOAD;
  endsequence
  a_fuse_copy_select: assert property (s_load |=> sel_field_reg == $past(clock_select_fuses)) // see R1
    else $error("select field not loaded from fuses");
  a_div8_from_fuse: assert property (s_load ##0 !divide_by_eight_fuse |=> div_en_reg) // see R6
    else $error("programmed divide fuse not honoured");
  a_switch_started: assert property (clk_en && sw_req && new_src != sw_if.active // see R2
    |=> state_reg == ssctl_pkg::ST_SWITCH)
    else $error("switch request ignored while running");
  a_run_source_match: assert property (clk_en && state_reg == ssctl_pkg::ST_WAKE // see R3
    && ck_done && !ck_start_reg |-> sw_if.active == decode_src(sel_field_reg))
    else $error("active source differs from select field");
  a_osc_pins: assert property (clk_en && sw_if.active == ssctl_pkg::SRC_XTAL // see R5
    ##1 clk_en |-> osc_pins_dedicated && !port_b_pin_four_clk_in)
    else $error("crystal source without oscillator pins");
  a_no_run_in_wake: assert property (state_reg == ssctl_pkg::ST_WAKE ##1 clk_en |-> !cpu_run) // see R7
    else $error("core running during start-up");
  a_reset_delay_holds: assert property (clk_en && state_reg == ssctl_pkg::ST_RST_WDT // see R8
    && (!wdt_done || wdt_start_reg) |=> state_reg == ssctl_pkg::ST_RST_WDT)
    else $error("reset delay ended early");
  a_short_delay_len: assert property (clk_en && state_reg == ssctl_pkg::ST_RST_CK // see R9
    && ck_done && !ck_start_reg && startup_field_reg == `SSCTL_STARTUP_SHORT
    |=> wdt_target_reg == `SSCTL_RESET_SHORT_WDT)
    else $error("short reset delay not 512 cycles");
  a_core_halted: assert property (clk_en && !core_en |=> !core_clock_tick) // see R13
    else $error("core clock ticked while halted");
  a_conv_in_sleep: assert property (clk_en && state_reg == ssctl_pkg::ST_SLEEP && sys_tick_w
    && !gate_reg[4] |=> converter_clock_tick && !core_clock_tick) // see R16
    else $error("converter clock stopped in sleep");
  a_bus_ack_drop: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

// [ssctl_map.svh]
`ifndef SSCTL_MAP_SVH
`define SSCTL_MAP_SVH
// How it works
// (R1) after reset the source comes from the clock select fuses, no software needed
// (R2) software may switch the running system clock to any other source
// (R3) code 0000 external clock, 0010 internal RC, 0011 watchdog oscillator
// (R4) 01xx low-frequency oscillator; 100x..111x crystal ranges, bit 0 free
// (R5) external clock takes one pin; oscillators take both pins; internal frees both
// (R6) a fuse bit of one is unprogrammed, zero is programmed
// (R7) wake-up and source switch count start-up on the selected source first
// (R8) reset adds a power delay counted on watchdog oscillator cycles
// (R9) reset delay offers 512 and 8192 watchdog cycles
// (R10) reset copies fuse fields into the selection register, which then rules
// (R11) factory fuses give internal RC, longest start-up, clock divided by eight
// (R12) clocks of unused modules can be gated by sleep or by software
// (R13) a halted core clock stops all core activity
// (R14) peripheral clock drives most modules; some interrupts seen without it
// (R15) async timer has its own clock and keeps counting in sleep
// (R16) converter clock runs on while core and peripheral clocks halt
// (R17) software must switch clocks carefully to avoid bad settings
// (R18) internal sources: wake 6 cycles, reset 14 plus optional 512 or 8192
// (R19) source handover never produces shortened clock pulses

// register byte addresses
`define SSCTL_ADR_SELECT 4'h0
`define SSCTL_ADR_GATE 4'h4
`define SSCTL_ADR_STATUS 4'h8
// selection register fields
`define SSCTL_SWITCH_BIT 8
`define SSCTL_DIV8_BIT 9
// source select codes
`define SSCTL_CODE_EXT 4'h0
`define SSCTL_CODE_RC 4'h2
`define SSCTL_CODE_WDT 4'h3
// start-up field codes
`define SSCTL_STARTUP_NONE 2'h0
`define SSCTL_STARTUP_SHORT 2'h1
// reset values
`define SSCTL_GATE_RESET 5'h00
// timing counts, in cycles of the source named
`define SSCTL_WAKE_CK 14'h0006
`define SSCTL_OSC_WAKE_CK 14'h0102
`define SSCTL_RESET_CK 14'h000e
`define SSCTL_RESET_SHORT_WDT 14'h0200
`define SSCTL_RESET_LONG_WDT 8192
`endif

// [ssctl_pkg.sv]
package ssctl_pkg;
  // clock sources, index order matches the source level vector
  typedef enum logic [2:0] {SRC_EXT, SRC_RC, SRC_WDT, SRC_LF, SRC_XTAL} ssctl_src_t;
  // control sequence states
  typedef enum logic [2:0] {
    ST_LOAD, ST_RST_SW, ST_RST_CK, ST_RST_WDT, ST_RUN, ST_SWITCH, ST_SLEEP, ST_WAKE
  } ssctl_state_t;
endpackage

// [ssctl_sw_if.sv]
`timescale 1ns/1ps
interface ssctl_sw_if;
  logic [4:0] levels;
  ssctl_pkg::ssctl_src_t req;
  logic go;
  ssctl_pkg::ssctl_src_t active;
  logic clk_level;
  logic busy;
  modport ctl (output levels, output req, output go, input active, input clk_level, input busy);
  modport sw (input levels, input req, input go, output active, output clk_level, output busy);
endinterface

// [ssctl_tick_counter.sv]
`timescale 1ns/1ps
module ssctl_tick_counter #(
  parameter int W = 14
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset
  input wire logic clk_en, // freezes state when low
  input wire logic start, // clears and starts a count
  input wire logic tick, // one source cycle
  input wire logic [W-1:0] target, // cycles to count
  output logic done // count finished
);
  logic [W-1:0] cnt_reg;
  logic run_reg;

  // count ticks up to the target, then stop
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start)
      begin
        cnt_reg <= '0;
        run_reg <= (target != '0);
      end
      else if (run_reg && tick)
      begin
        cnt_reg <= cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 == target)
          run_reg <= 1'b0;
      end
    end

  assign done = !run_reg && !start;
endmodule

// [ssctl_clk_switch.sv]
`timescale 1ns/1ps
module ssctl_clk_switch (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset
  input wire logic clk_en, // freezes state when low
  ssctl_sw_if.sw sw // handover control
);
  typedef enum logic [1:0] {HS_IDLE, HS_DRAIN, HS_FILL} ssctl_hs_t;
  ssctl_hs_t hs_reg;
  logic on_reg;

  // release the old source only while low, engage the new one only while low
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      hs_reg <= HS_IDLE;
      on_reg <= 1'b0;
      sw.active <= ssctl_pkg::SRC_RC;
    end
    else if (clk_en)
    begin
      case (hs_reg)
        HS_IDLE:
          if (sw.go && (sw.req != sw.active || !on_reg))
            hs_reg <= HS_DRAIN;
        HS_DRAIN:
          if (!sw.levels[sw.active] || !on_reg) // see R19
          begin
            on_reg <= 1'b0;
            sw.active <= sw.req;
            hs_reg <= HS_FILL;
          end
        HS_FILL:
          if (!sw.levels[sw.active]) // see R19
          begin
            on_reg <= 1'b1;
            hs_reg <= HS_IDLE;
          end
        default:
          hs_reg <= HS_IDLE;
      endcase
    end

  assign sw.clk_level = on_reg && sw.levels[sw.active];
  assign sw.busy = (hs_reg != HS_IDLE);

  sequence s_go;
    sw.go && sw.req != sw.active;
  endsequence
  a_handover_starts: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R2
    s_go ##0 clk_en ##0 !sw.busy |=> sw.busy)
    else $error("switch request did not start handover");
  a_handover_low: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R19
    clk_en && hs_reg == HS_DRAIN && sw.levels[sw.active] && on_reg |=> sw.busy && on_reg)
    else $error("old source released while high");
endmodule

// [ssctl_osc_model.sv]
`timescale 1ns/1ps
module ssctl_osc_model (
  output logic ext_clk, // external clock level
  output logic rc_clk, // internal rc level
  output logic wdt_clk, // watchdog oscillator level
  output logic lf_clk, // low-frequency level
  output logic xtal_clk // crystal level
);
  // real oscillators run free, at phases unrelated to the system clock
  initial
  begin
    {ext_clk, rc_clk, wdt_clk, lf_clk, xtal_clk} = 5'h00;
  end
  // one toggle process per source
  always #90 ext_clk = ~ext_clk;
  always #70 rc_clk = ~rc_clk;
  always #110 wdt_clk = ~wdt_clk;
  always #230 lf_clk = ~lf_clk;
  always #130 xtal_clk = ~xtal_clk;
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "ssctl_map.svh"
module tb_top;
  logic clk_sys, arst_n, cyc, stb, we, slp, wak, int_n, fdiv;
  logic [3:0] adr, fsel, sel;
  logic [1:0] fsut;
  logic [31:0] wdat, rdat, q;
  logic ack, tick, pin4, pins2, iwake, run, cko;
  logic [4:0] dom;
  logic [4:0] osc;
  int num_errors = 0;
  int num_checks = 0;
  int cnt [5];
  int nco;
  realtime t0;
  localparam int LONGW = 20;
  localparam real PER [5] = '{180.0, 140.0, 220.0, 460.0, 260.0};
  localparam logic [3:0] CODES [7] = '{4'h0, 4'h7, 4'h3, 4'h8, 4'h4, 4'hf, 4'h2};
  localparam logic [2:0] SRCS [7] = '{3'h0, 3'h3, 3'h2, 3'h4, 3'h3, 3'h4, 3'h1};
  ssctl_osc_model osc_m (.ext_clk(osc[0]), .rc_clk(osc[1]), .wdt_clk(osc[2]),
    .lf_clk(osc[3]), .xtal_clk(osc[4]));
  ssctl_top #(.RESET_LONG_CYCLES(LONGW)) uut (.clk_sys(clk_sys), .arst_n(arst_n),
    .clk_en(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .clock_select_fuses(fsel), .startup_time_fuses(fsut), .divide_by_eight_fuse(fdiv),
    .external_clock_input(osc[0]), .rc_osc_clk(osc[1]), .watchdog_timer_osc_clk(osc[2]),
    .lf_osc_clk(osc[3]), .xtal_osc_clk(osc[4]), .sleep_req(slp), .wake_evt(wak),
    .ext_int_n(int_n), .sys_clk_tick(tick), .core_clock_tick(dom[0]),
    .peripheral_clock_tick(dom[1]), .program_memory_clock_tick(dom[2]),
    .async_timer_clock_tick(dom[3]), .converter_clock_tick(dom[4]), .cpu_run(run),
    .clock_output_pin(cko), .port_b_pin_four_clk_in(pin4), .osc_pins_dedicated(pins2),
    .async_int_wake(iwake));
  // clock, offset so source edges never meet its edges
  initial
  begin
    clk_sys = 1'b0;
    #7;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one classic cycle; read data lands in q
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic wait_run(input int n);
    for (int i = 0; i < n && run !== 1'b1; i++) @(posedge clk_sys);
    chk("cpu_run", 32'(run), 32'h1);
  endtask
  task automatic wait_tick;
    do @(posedge clk_sys); while (tick !== 1'b1);
  endtask
  task automatic count_ticks;
    logic last;
    cnt = '{default: 0};
    nco = 0;
    // first edge still shows ticks launched before the last change
    @(posedge clk_sys);
    last = cko;
    repeat (300) @(posedge clk_sys)
    begin
      for (int k = 0; k < 5; k++) cnt[k] += int'(dom[k]);
      nco += int'(cko && !last);
      last = cko;
    end
  endtask
  // reset with given fuses, time the start-up, check what was loaded
  task automatic do_reset(input logic [3:0] s, input logic [1:0] u, input logic dv,
    input int src, input real wd);
    real lo, hi;
    arst_n <= 1'b0;
    fsel <= s;
    fsut <= u;
    fdiv <= dv;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t0 = $realtime;
    // the first counted edge may come at once, so the floor is one period short
    lo = 13.0 * PER[src] + (wd > 0.0 ? wd - 1.0 : 0.0) * 220.0;
    hi = 17.0 * PER[src] + wd * 220.0 + 400.0;
    wait_run(10000);
    chk("delay low", 32'($realtime - t0 >= lo), 32'h1);
    chk("delay high", 32'($realtime - t0 <= hi), 32'h1);
    bus(1'b0, `SSCTL_ADR_STATUS, 32'h0);
    chk("source", 32'(q[2:0]), 32'(src));
    bus(1'b0, `SSCTL_ADR_SELECT, 32'h0);
    chk("select copy", 32'(q[5:0]), 32'({u, s}));
    $display("test reset %h done", s);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial
  begin
    #3_000_000;
    num_errors++;
    summarize();
  end
  // main sequence
  initial
  begin
    {arst_n, cyc, stb, we, slp, wak, adr, sel, wdat} = '0;
    {int_n, fdiv, fsel, fsut} = 8'hff;
    do_reset(4'h0, 2'h1, 1'b1, 0, 512.0);
    chk("pin4 ext", 32'(pin4), 32'h1);
    do_reset(4'h3, 2'h0, 1'b1, 2, 0.0);
    do_reset(4'h2, 2'h2, 1'b0, 1, real'(LONGW));
    wait_tick();
    t0 = $realtime;
    repeat (8) wait_tick();
    chk("div8", 32'(($realtime - t0 - 8960.0) ** 2 <= 6400.0), 32'h1);
    do_reset(4'h2, 2'h0, 1'b1, 1, 0.0);
    // switch through every kind of source; a write during the switch is ignored
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, `SSCTL_ADR_SELECT, 32'h100 | 32'(CODES[i]));
      bus(1'b1, `SSCTL_ADR_SELECT, 32'h100 | 32'(CODES[i] ^ 4'h8));
      wait_run(4000);
      bus(1'b0, `SSCTL_ADR_STATUS, 32'h0);
      chk("switched", 32'({q[10:8], q[2:0]}), 32'({3'h4, SRCS[i]}));
      chk("pin4", 32'(pin4), 32'(CODES[i] == 4'h0));
      chk("osc pins", 32'(pins2), 32'(CODES[i][3:2] != 2'h0));
      bus(1'b0, `SSCTL_ADR_SELECT, 32'h0);
      chk("select", 32'({q[8], q[5:0]}), 32'(CODES[i]));
    end
    $display("test switch done");
    // gate one domain at a time
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b1, `SSCTL_ADR_GATE, 32'h1 << k);
      count_ticks();
      chk("gated", 32'(cnt[k]), 32'h0);
      chk("ungated", 32'(cnt[(k + 1) % 5] > 0), 32'h1);
      chk("core halt", 32'(run), 32'(k != 0));
      chk("clock out", 32'(nco > 0), 32'h1);
    end
    bus(1'b1, `SSCTL_ADR_GATE, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test gate done");
    // sleep: async and converter run on, interrupt seen, timed wake
    @(posedge clk_sys) slp <= 1'b1;
    @(posedge clk_sys) slp <= 1'b0;
    count_ticks();
    chk("core sleep", 32'(cnt[0] + cnt[1] + cnt[2]), 32'h0);
    chk("async runs", 32'(cnt[3] > 0), 32'h1);
    chk("adc runs", 32'(cnt[4] > 0), 32'h1);
    chk("int idle", 32'(iwake), 32'h0);
    int_n <= 1'b0;
    @(posedge clk_sys) int_n <= 1'b1;
    chk("async int", 32'(iwake), 32'h1);
    wak <= 1'b1;
    t0 = $realtime;
    @(posedge clk_sys) wak <= 1'b0;
    wait_run(1000);
    chk("wake time", 32'($realtime - t0 >= 840.0 && $realtime - t0 <= 1320.0), 32'h1);
    $display("test sleep done");
    summarize();
  end
endmodule
